// File: hdl/uart_baud_tick.sv
`timescale 1ns/1ps
`include "uart_consts.svh"

// Two-stage divider: power-of-two prescaler, then reload counter.
// One tick is half a bit period.
module uart_baud_tick #(
	parameter int PS_W  = 3,
	parameter int DIV_W = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	input  wire logic             restart,
	input  wire logic [PS_W-1:0]  prescale_select,
	input  wire logic [DIV_W-1:0] baud_reload_divider,
	output logic                  tick
);

	localparam int PRE_W = (1 << PS_W) - 1;

	logic [PRE_W-1:0] pre_cnt_r;  // Prescaler count
	logic [PRE_W-1:0] pre_mask;   // Low bits that must be all ones
	logic             pre_en;     // Main clock enable
	logic [DIV_W-1:0] div_cnt_r;  // Reload counter

	// Mask of 2^sel - 1 selects the division
	assign pre_mask = PRE_W'((1 << prescale_select) - 1);
	assign pre_en   = ((pre_cnt_r & pre_mask) == pre_mask);

	// Prescaler, cleared on restart so a frame starts in phase
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_cnt_r <= '0;
		end else if (restart) begin
			pre_cnt_r <= '0;
		end else begin
			pre_cnt_r <= pre_cnt_r + PRE_W'(1);
		end
	end

	// Counts up from reload to all ones: 256 - reload prescaler enables
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_r <= '0;
		end else if (restart) begin
			div_cnt_r <= baud_reload_divider;
		end else if (pre_en) begin
			if (div_cnt_r == '1) begin
				div_cnt_r <= baud_reload_divider;
			end else begin
				div_cnt_r <= div_cnt_r + DIV_W'(1);
			end
		end
	end

	// Enable taken straight off the counter: a register stage here would
	// stretch the first half bit after a restart by one clock
	assign tick = pre_en && (div_cnt_r == '1) && !restart;

endmodule : uart_baud_tick

// File: hdl/uart_transceiver_baud_gen.sv
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "uart_consts.svh"

module uart_transceiver_baud_gen #(
	parameter int DATA_W = 8,
	parameter int PS_W   = 3
) (
	input  wire logic                sys_clk,
	input  wire logic                reset_n,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [7:0]               reg_rdata,
	input  wire logic                rx_pin_i,
	output uart_pkg::pin_drive_t     rx_pin,
	output uart_pkg::pin_drive_t     tx_pin,
	input  wire uart_pkg::pin_drive_t gpio_rx,
	input  wire uart_pkg::pin_drive_t gpio_tx,
	output logic                     rx_irq_req,
	output logic                     tx_irq_req,
	output logic [15:0]              irq_vector
);

	// Control registers
	logic [7:0]        tx_ctrl_r;   // Enable, parity, break
	logic [7:0]        rx_ctrl_r;   // Enable, parity, prescaler
	logic [7:0]        baud_reload_divider_r;
	logic [DATA_W-1:0] tx_data_buffer_r;
	logic [DATA_W-1:0] rx_data_buffer_r;
	logic              rx_irq_enable_r;
	logic              tx_irq_enable_r;
	logic              rx_irq_flag_r;
	logic              tx_irq_flag_r;
	logic              parity_error_flag_r;
	logic              frame_error_flag_r;

	// Write decode
	logic wr_tx_ctrl;
	logic wr_rx_ctrl;
	logic wr_div;
	logic wr_tx_data;
	logic wr_irq;

	// Transmit path
	uart_pkg::tx_state_t tx_state_r;
	logic [5:0]          tx_tick_cnt_r;   // Ticks within a bit or break
	logic [2:0]          tx_bit_r;        // Data bit index
	logic [DATA_W-1:0]   tx_shift_r;      // Byte being sent
	logic                tx_line_r;       // Serial output level
	logic                tx_done;         // Frame or break finished
	logic                tx_go;           // Start a data frame
	logic                brk_go;          // Start a break
	logic                tx_tick;
	logic                tx_bit_end;      // Last tick of a bit

	// Receive path
	uart_pkg::rx_state_t rx_state_r;
	logic                rx_tick_cnt_r;
	logic [2:0]          rx_bit_r;
	logic [DATA_W-1:0]   rx_shift_r;
	logic                rx_prev_r;       // Line one cycle ago
	logic                rx_start_bad_r;  // Start bit not low at centre
	logic                rx_par_r;        // Received parity bit
	logic                rx_fall;
	logic                rx_tick;
	logic                rx_sample;       // Bit centre
	logic                rx_done;

	// Field aliases
	logic tx_en;
	logic rx_en;

	assign tx_en = tx_ctrl_r[`TXC_EN];
	assign rx_en = rx_ctrl_r[`RXC_EN];

	assign wr_tx_ctrl = reg_wr && (reg_addr == `ADDR_TX_CTRL);
	assign wr_rx_ctrl = reg_wr && (reg_addr == `ADDR_RX_CTRL);
	assign wr_div     = reg_wr && (reg_addr == `ADDR_BAUD_DIV);
	assign wr_tx_data = reg_wr && (reg_addr == `ADDR_TX_DATA);
	assign wr_irq     = reg_wr && (reg_addr == `ADDR_IRQ_CTRL);

	// Pin ownership: serial when enabled, else the GPIO drive passed straight through
	always_comb begin
		if (tx_en) begin
			tx_pin.o  = tx_line_r;
			tx_pin.oe = 1'b1;
		end else begin
			tx_pin = gpio_tx;
		end
		if (rx_en) begin
			rx_pin.o  = 1'b0;
			rx_pin.oe = 1'b0;
		end else begin
			rx_pin = gpio_rx;
		end
	end

	// Two dividers so each direction keeps its own phase
	uart_baud_tick #(.PS_W(PS_W), .DIV_W(8)) u_tx_baud (
		.sys_clk             (sys_clk),
		.reset_n             (reset_n),
		.restart             (tx_go || brk_go),
		.prescale_select     (rx_ctrl_r[`RXC_PS_HI:`RXC_PS_LO]),
		.baud_reload_divider (baud_reload_divider_r),
		.tick                (tx_tick)
	);

	uart_baud_tick #(.PS_W(PS_W), .DIV_W(8)) u_rx_baud (
		.sys_clk             (sys_clk),
		.reset_n             (reset_n),
		.restart             (rx_fall),
		.prescale_select     (rx_ctrl_r[`RXC_PS_HI:`RXC_PS_LO]),
		.baud_reload_divider (baud_reload_divider_r),
		.tick                (rx_tick)
	);

	// Software registers; break bit self-clears when done
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_ctrl_r             <= `CTRL_RST;
			rx_ctrl_r             <= `CTRL_RST;
			baud_reload_divider_r <= `BAUD_DIV_RST;
			tx_data_buffer_r      <= `DATA_RST;
			rx_irq_enable_r       <= 1'b0;
			tx_irq_enable_r       <= 1'b0;
		end else begin
			if (wr_tx_ctrl) begin
				// Busy bits are read-only
				tx_ctrl_r[7:4] <= reg_wdata[7:4];
			end else if ((tx_state_r == uart_pkg::TX_BRK) && tx_done) begin
				tx_ctrl_r[`TXC_BRK] <= 1'b0;
			end
			if (wr_rx_ctrl) begin
				rx_ctrl_r <= reg_wdata;
			end
			if (wr_div) begin
				// All ones is legal here and gives the fastest rate, one tick per prescaler enable
				baud_reload_divider_r <= reg_wdata;
			end
			if (wr_tx_data) begin
				// Single holding byte, no queue behind it
				tx_data_buffer_r <= reg_wdata;
			end
			if (wr_irq) begin
				rx_irq_enable_r <= reg_wdata[`IRQ_RX_EN];
				tx_irq_enable_r <= reg_wdata[`IRQ_TX_EN];
			end
		end
	end

	// Interrupt flags sticky, error flags reloaded each frame; hardware wins over a software write
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_irq_flag_r       <= 1'b0;
			tx_irq_flag_r       <= 1'b0;
			parity_error_flag_r <= 1'b0;
			frame_error_flag_r  <= 1'b0;
		end else begin
			if (rx_done) begin
				rx_irq_flag_r <= 1'b1;
			end else if (wr_irq) begin
				rx_irq_flag_r <= reg_wdata[`IRQ_RX_FLAG];
			end
			if (tx_done) begin
				tx_irq_flag_r <= 1'b1;
			end else if (wr_irq) begin
				tx_irq_flag_r <= reg_wdata[`IRQ_TX_FLAG];
			end
			if (rx_done) begin
				// Checked only when parity is in the frame
				parity_error_flag_r <= rx_ctrl_r[`RXC_PAR_EN]
					&& (rx_par_r != (^rx_shift_r ^ rx_ctrl_r[`RXC_PAR_OD]));
				// Stop sampled now; start checked earlier
				frame_error_flag_r <= rx_start_bad_r || !rx_pin_i;
			end else if (wr_rx_ctrl) begin
				parity_error_flag_r <= reg_wdata[`RXC_PERR];
				frame_error_flag_r  <= reg_wdata[`RXC_FERR];
			end
		end
	end

	// Interrupt requests and service address, receive first
	assign rx_irq_req = rx_irq_flag_r && rx_irq_enable_r;
	assign tx_irq_req = tx_irq_flag_r && tx_irq_enable_r;
	assign irq_vector = rx_irq_req ? `RX_VECTOR :
		(tx_irq_req ? `TX_VECTOR : 16'h0000);

	// Read data stand in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `ADDR_TX_CTRL) begin
				reg_rdata <= {tx_ctrl_r[7:4], rx_state_r != uart_pkg::RX_HUNT,
					tx_state_r != uart_pkg::TX_IDLE, 2'b00};
			end else if (reg_addr == `ADDR_RX_CTRL) begin
				reg_rdata <= {rx_ctrl_r[7:5], parity_error_flag_r,
					frame_error_flag_r, rx_ctrl_r[2:0]};
			end else if (reg_addr == `ADDR_BAUD_DIV) begin
				reg_rdata <= baud_reload_divider_r;
			end else if (reg_addr == `ADDR_TX_DATA) begin
				reg_rdata <= tx_data_buffer_r;
			end else if (reg_addr == `ADDR_RX_DATA) begin
				reg_rdata <= rx_data_buffer_r;
			end else if (reg_addr == `ADDR_IRQ_CTRL) begin
				reg_rdata <= {4'h0, tx_irq_flag_r, rx_irq_flag_r,
					tx_irq_enable_r, rx_irq_enable_r};
			end else begin
				// Unmapped addresses read zero
				reg_rdata <= 8'h00;
			end
		end
	end

	// Transmit starts: data write or break request while idle
	assign tx_go  = wr_tx_data && tx_en && (tx_state_r == uart_pkg::TX_IDLE);
	assign brk_go = wr_tx_ctrl && reg_wdata[`TXC_EN] && reg_wdata[`TXC_BRK]
		&& (tx_state_r == uart_pkg::TX_IDLE);
	assign tx_bit_end = tx_tick && (tx_tick_cnt_r == 6'(`TICKS_PER_BIT - 1));
	assign tx_done = ((tx_state_r == uart_pkg::TX_STOP) && tx_bit_end)
		|| ((tx_state_r == uart_pkg::TX_BRK) && tx_tick
		&& (tx_tick_cnt_r == 6'(`BRK_TICKS - 1)));

	// Transmit tick counter, two ticks per bit
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_tick_cnt_r <= 6'h00;
		end else if (tx_go || brk_go || tx_bit_end && tx_state_r != uart_pkg::TX_BRK) begin
			tx_tick_cnt_r <= 6'h00;
		end else if (tx_tick) begin
			tx_tick_cnt_r <= tx_tick_cnt_r + 6'h01;
		end
	end

	// Transmit sequencer
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_state_r <= uart_pkg::TX_IDLE;
			tx_bit_r   <= 3'h0;
			tx_shift_r <= `DATA_RST;
			tx_line_r  <= 1'b1;
		end else begin
			case (tx_state_r)
				uart_pkg::TX_IDLE: begin
					tx_line_r <= 1'b1;
					if (brk_go) begin
						tx_state_r <= uart_pkg::TX_BRK;
						tx_line_r  <= 1'b0;
					end else if (tx_go) begin
						tx_shift_r <= reg_wdata;
						tx_bit_r   <= 3'h0;
						tx_state_r <= uart_pkg::TX_START;
						tx_line_r  <= 1'b0;
					end
				end
				uart_pkg::TX_START: begin
					if (tx_bit_end) begin
						tx_state_r <= uart_pkg::TX_DATA;
						tx_line_r  <= tx_shift_r[0];
					end
				end
				uart_pkg::TX_DATA: begin
					if (tx_bit_end) begin
						tx_bit_r <= tx_bit_r + 3'h1;
						if (tx_bit_r == 3'h7) begin
							if (tx_ctrl_r[`TXC_PAR_EN]) begin
								tx_state_r <= uart_pkg::TX_PAR;
								tx_line_r  <= ^tx_shift_r ^ tx_ctrl_r[`TXC_PAR_OD];
							end else begin
								tx_state_r <= uart_pkg::TX_STOP;
								tx_line_r  <= 1'b1;
							end
						end else begin
							tx_line_r <= tx_shift_r[tx_bit_r + 3'h1];
						end
					end
				end
				uart_pkg::TX_PAR: begin
					if (tx_bit_end) begin
						tx_state_r <= uart_pkg::TX_STOP;
						tx_line_r  <= 1'b1;
					end
				end
				uart_pkg::TX_STOP, uart_pkg::TX_BRK: begin
					if (tx_done) begin
						tx_state_r <= uart_pkg::TX_IDLE;
						tx_line_r  <= 1'b1;
					end
				end
				default: begin
					tx_state_r <= uart_pkg::TX_IDLE;
				end
			endcase
		end
	end

	// Start edge: line was high and is now low
	assign rx_fall = rx_en && (rx_state_r == uart_pkg::RX_HUNT)
		&& rx_prev_r && !rx_pin_i;
	// First tick is mid start bit, then every second tick
	assign rx_sample = rx_tick && ((rx_state_r == uart_pkg::RX_START) || rx_tick_cnt_r);
	assign rx_done = rx_sample && (rx_state_r == uart_pkg::RX_STOP);

	// Line history for edge detection
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_prev_r <= 1'b1;
		end else begin
			rx_prev_r <= rx_pin_i;
		end
	end

	// Receive tick phase
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_tick_cnt_r <= 1'b0;
		end else if (rx_fall || rx_sample) begin
			rx_tick_cnt_r <= 1'b0;
		end else if (rx_tick) begin
			rx_tick_cnt_r <= 1'b1;
		end
	end

	// Receive sequencer; a bad frame still runs to its stop bit
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_state_r       <= uart_pkg::RX_HUNT;
			rx_bit_r         <= 3'h0;
			rx_shift_r       <= `DATA_RST;
			rx_start_bad_r   <= 1'b0;
			rx_par_r         <= 1'b0;
			rx_data_buffer_r <= `DATA_RST;
		end else begin
			case (rx_state_r)
				uart_pkg::RX_HUNT: begin
					if (rx_fall) begin
						rx_state_r <= uart_pkg::RX_START;
						rx_bit_r   <= 3'h0;
					end
				end
				uart_pkg::RX_START: begin
					if (rx_sample) begin
						rx_start_bad_r <= rx_pin_i;
						rx_state_r     <= uart_pkg::RX_DATA;
					end
				end
				uart_pkg::RX_DATA: begin
					if (rx_sample) begin
						rx_shift_r <= {rx_pin_i, rx_shift_r[DATA_W-1:1]};
						rx_bit_r   <= rx_bit_r + 3'h1;
						if (rx_bit_r == 3'h7) begin
							rx_state_r <= rx_ctrl_r[`RXC_PAR_EN] ?
								uart_pkg::RX_PAR : uart_pkg::RX_STOP;
						end
					end
				end
				uart_pkg::RX_PAR: begin
					if (rx_sample) begin
						rx_par_r   <= rx_pin_i;
						rx_state_r <= uart_pkg::RX_STOP;
					end
				end
				uart_pkg::RX_STOP: begin
					if (rx_done) begin
						// One receive byte; next frame overwrites it
						rx_data_buffer_r <= rx_shift_r;
						rx_state_r       <= uart_pkg::RX_HUNT;
					end
				end
				default: begin
					rx_state_r <= uart_pkg::RX_HUNT;
				end
			endcase
		end
	end

endmodule : uart_transceiver_baud_gen

// File: shared/uart_consts.svh
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH

// Register byte addresses
`define ADDR_IRQ_CTRL 8'hE3
`define ADDR_TX_CTRL  8'hE4
`define ADDR_RX_CTRL  8'hE5
`define ADDR_BAUD_DIV 8'hE6
`define ADDR_TX_DATA  8'hE7
`define ADDR_RX_DATA  8'hE8

// Transmit control fields
`define TXC_EN     7
`define TXC_PAR_EN 6
`define TXC_PAR_OD 5
`define TXC_BRK    4
`define TXC_RXBZ   3
`define TXC_TXBZ   2

// Receive control fields
`define RXC_EN     7
`define RXC_PAR_EN 6
`define RXC_PAR_OD 5
`define RXC_PERR   4
`define RXC_FERR   3
`define RXC_PS_HI  2
`define RXC_PS_LO  0

// Interrupt control fields
`define IRQ_RX_EN   0
`define IRQ_TX_EN   1
`define IRQ_RX_FLAG 2
`define IRQ_TX_FLAG 3

// Reset values
`define CTRL_RST     8'h00
`define BAUD_DIV_RST 8'h00
`define DATA_RST     8'h00

// Timing: baud clock is two divider ticks
`define TICKS_PER_BIT 2
`define BRK_BAUD_CLKS 25
`define BRK_TICKS     (`BRK_BAUD_CLKS * `TICKS_PER_BIT)

// Service addresses
`define RX_VECTOR 16'h0013
`define TX_VECTOR 16'h0014

`endif

// File: shared/uart_pkg.sv
package uart_pkg;

	// Drive of a shared pin
	typedef struct packed {
		logic o;
		logic oe;
	} pin_drive_t;

	// Transmitter states
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100,
		TX_BRK   = 3'b101
	} tx_state_t;

	// Receiver states
	typedef enum logic [2:0] {
		RX_HUNT  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} rx_state_t;

endpackage : uart_pkg

// File: testbench/uart_serial_peer.sv
`timescale 1ns/1ps
// Far-side serial device at a fixed bit period
module uart_serial_peer #(
	parameter int BIT_CYC = 4 // Clocks per bit; bench runs ps 0, divider FE
) (
	input  wire logic sys_clk,
	input  wire logic tx_line, // Resolved transmit wire
	output logic      rx_line  // Wire into the receiver
);
	initial rx_line = 1'b1; // Idle high, as a line driver parks it

	// Send one frame; the two flags corrupt it on command only
	task automatic send(input logic [7:0] d, input logic pen, odd, bad_par, bad_stop);
		logic [10:0] f;
		int          n;
		n = pen ? 11 : 10;
		f = pen ? {~bad_stop, ^d ^ odd ^ bad_par, d, 1'b0} : {1'b1, ~bad_stop, d, 1'b0};
		for (int i = 0; i < n; i++) begin
			rx_line <= f[i];
			repeat (BIT_CYC) @(posedge sys_clk);
		end
		// Back to idle so the next start is a clean edge
		rx_line <= 1'b1;
		repeat (BIT_CYC) @(posedge sys_clk);
	endtask : send

	// Capture eleven bit centres after a start edge
	task automatic recv(output logic [10:0] f, output logic ok);
		// The start bit may already stand when this is called
		ok = (tx_line === 1'b0);
		for (int t = 0; t < 5000 && !ok; t++) begin
			@(posedge sys_clk);
			ok = (tx_line === 1'b0);
		end
		repeat (BIT_CYC / 2) @(posedge sys_clk);
		for (int i = 0; i < 11; i++) begin
			f[i] = tx_line;
			repeat (BIT_CYC) @(posedge sys_clk);
		end
	endtask : recv
endmodule : uart_serial_peer

// File: testbench/uart_transceiver_baud_gen_tb.sv
`timescale 1ns/1ps
// Register-driven bench for the serial transceiver
module uart_transceiver_baud_gen_tb;
	logic                 sys_clk;    // 100 MHz
	logic                 reset_n;    // Async, active low
	logic [7:0]           reg_addr;   // Register bus
	logic [7:0]           reg_wdata;
	logic                 reg_wr;
	logic                 reg_rd;
	logic [7:0]           reg_rdata;
	logic                 rx_pin_i;   // Resolved receive wire
	logic                 peer_line;  // Far side drive
	logic                 tx_line;    // Resolved transmit wire
	uart_pkg::pin_drive_t rx_pin;
	uart_pkg::pin_drive_t tx_pin;
	uart_pkg::pin_drive_t gpio_rx;
	uart_pkg::pin_drive_t gpio_tx;
	logic                 rx_irq_req;
	logic                 tx_irq_req;
	logic [15:0]          irq_vector;
	int                   n_fail;
	int                   n_checks;
	logic [7:0]           d;
	logic [7:0]           cfg;
	logic [7:0]           td;
	logic [7:0]           rdv;
	logic [10:0]          f;
	logic                 ok;
	int                   n;
	int                   ps_t [5] = '{1, 2, 3, 7, 0};          // Prescale codes
	logic [7:0]           dv_t [5] = '{8'hFD, 8'hFC, 8'hF0, 8'hFE, 8'hFE}; // Never FF

	// Pull-up on the transmit wire; receive wire from whoever drives
	assign tx_line  = tx_pin.oe ? tx_pin.o : 1'b1;
	assign rx_pin_i = rx_pin.oe ? rx_pin.o : peer_line;

	always #5 sys_clk = ~sys_clk;

	uart_transceiver_baud_gen u_uart_transceiver_baud_gen (.sys_clk(sys_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_pin_i(rx_pin_i), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.gpio_rx(gpio_rx), .gpio_tx(gpio_tx), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req),
		.irq_vector(irq_vector));

	uart_serial_peer u_uart_serial_peer (.sys_clk(sys_clk), .tx_line(tx_line), .rx_line(peer_line));

	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// Compare one value
	task automatic chk(input logic [15:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One-cycle write strobe; an idle edge follows so that a second call
	// never drives the strobe again in the step that lowered it
	task automatic wr(input logic [7:0] a, v);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr

	// Read strobe, data taken in the following cycle only
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		v = reg_rdata;
	endtask : rd

	task automatic rdchk(input logic [7:0] a, exp);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp);
	endtask : rdchk

	// Poll a completion flag; long frames at slow rates need the wide bound
	task automatic wait_flag(input int b);
		logic [7:0] v;
		for (int i = 0; i < 4000; i++) begin
			rd(8'hE3, v);
			if (v[b] === 1'b1) return;
		end
		n_fail++;
		summarize();
	endtask : wait_flag

	// Cycles until the transmit wire shows a level
	task automatic wait_lvl(input logic v, output int c);
		c = 0;
		while (tx_line !== v) begin
			@(posedge sys_clk);
			c++;
			if (c > 3000) begin
				n_fail++;
				summarize();
			end
		end
	endtask : wait_lvl

	initial begin
		sys_clk   = 1'b0;
		reset_n   = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		gpio_tx   = '{o: 1'b0, oe: 1'b1};
		gpio_rx   = '{o: 1'b1, oe: 1'b0};
		n_fail    = 0;
		n_checks  = 0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		// Reset values, unmapped and read-only places
		for (int a = 8'hE3; a <= 8'hE8; a++) rdchk(a[7:0], 8'h00);
		rdchk(8'hE0, 8'h00);
		chk(tx_pin, gpio_tx);
		wr(8'hE8, 8'h5A);
		rdchk(8'hE8, 8'h00);
		// Bit period for each prescale and divider pair, data 55 gives a clean bit
		for (int k = 0; k < 5; k++) begin
			wr(8'hE5, ps_t[k][7:0]);
			wr(8'hE6, dv_t[k]);
			rdchk(8'hE6, dv_t[k]);
			wr(8'hE4, 8'h80);
			wr(8'hE7, 8'h55);
			wait_lvl(1'b0, n);
			wait_lvl(1'b1, n);
			wait_lvl(1'b0, n);
			chk(n, 2 * (1 << ps_t[k]) * (256 - dv_t[k]));
			wait_flag(3);
			wr(8'hE3, 8'h00);
		end
		// Break: 25 bit times low, then flag and self-clear
		wr(8'hE4, 8'h90);
		wait_lvl(1'b0, n);
		wait_lvl(1'b1, n);
		chk(n, 25 * 4);
		wait_flag(3);
		rdchk(8'hE4, 8'h80);
		wr(8'hE3, 8'h00);
		// Corrupt parity, then corrupt stop; each frame still completes
		for (int e = 1; e < 3; e++) begin
			wr(8'hE5, 8'hC0);
			u_uart_serial_peer.send(8'h81, 1'b1, 1'b0, e == 1, e == 2);
			wait_flag(2);
			rdchk(8'hE5, e == 1 ? 8'hD0 : 8'hC8);
			rdchk(8'hE8, 8'h81);
			wr(8'hE3, 8'h00);
		end
		// Both directions at once in every parity mode
		wr(8'hE3, 8'h03);
		for (int m = 0; m < 3; m++) begin
			cfg = {1'b1, m != 0, m == 2, 5'h00};
			td  = 8'hA5 ^ m[7:0];
			rdv = 8'h3C + m[7:0];
			wr(8'hE4, cfg);
			wr(8'hE5, cfg);
			wr(8'hE7, td);
			fork
				u_uart_serial_peer.recv(f, ok);
				u_uart_serial_peer.send(rdv, cfg[6], cfg[5], 1'b0, 1'b0);
				begin
					repeat (8) @(posedge sys_clk);
					rdchk(8'hE4, cfg | 8'h0C);
				end
			join
			chk(ok, 1'b1);
			chk(f[8:0], {td, 1'b0});
			chk(f[9], cfg[6] ? ^td ^ cfg[5] : 1'b1);
			chk(f[10], 1'b1);
			wait_flag(2);
			wait_flag(3);
			chk(irq_vector, 16'h0013);
			rdchk(8'hE8, rdv);
			rdchk(8'hE5, cfg);
			rdchk(8'hE4, cfg);
			wr(8'hE3, 8'h0B);
			@(posedge sys_clk);
			chk(irq_vector, 16'h0014);
			wr(8'hE3, 8'h03);
		end
		// Release both pins to the general-purpose drive
		wr(8'hE4, 8'h00);
		wr(8'hE5, 8'h00);
		gpio_tx <= '{o: 1'b1, oe: 1'b1};
		repeat (2) @(posedge sys_clk);
		chk(tx_pin, gpio_tx);
		chk(rx_pin, gpio_rx);
		summarize();
	end
endmodule : uart_transceiver_baud_gen_tb

// File: testbench/uart_transceiver_props.sv
`timescale 1ns/1ps
// Port-level checks for the serial transceiver
module uart_transceiver_props (
	input  wire logic                 sys_clk,
	input  wire logic                 reset_n,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_rdata,
	input  wire uart_pkg::pin_drive_t rx_pin,
	input  wire uart_pkg::pin_drive_t tx_pin,
	input  wire uart_pkg::pin_drive_t gpio_rx,
	input  wire uart_pkg::pin_drive_t gpio_tx,
	input  wire logic                 rx_irq_req,
	input  wire logic                 tx_irq_req,
	input  wire logic [15:0]          irq_vector
);
	logic [7:0] div_r; // Last divider written
	logic [7:0] txd_r; // Last transmit byte written
	logic [1:0] en_r;  // Serial enables: rx, tx
	logic [1:0] ie_r;  // Interrupt enables: rx, tx

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	// Shadow of fields that only software changes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_r <= 8'h00;
			txd_r <= 8'h00;
			en_r  <= 2'b00;
			ie_r  <= 2'b00;
		end else if (reg_wr) begin
			// Each write lands at the edge that takes it
			case (reg_addr)
				8'hE3: ie_r <= reg_wdata[1:0];
				8'hE4: en_r[1] <= reg_wdata[7];
				8'hE5: en_r[0] <= reg_wdata[7];
				8'hE6: div_r <= reg_wdata;
				8'hE7: txd_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	chk_vec_rx_first: assert property (rx_irq_req |-> irq_vector == 16'h0013)
		else $error("receive vector wrong");
	chk_vec_tx_only: assert property (!rx_irq_req && tx_irq_req |-> irq_vector == 16'h0014)
		else $error("transmit vector wrong");
	chk_vec_quiet: assert property (!rx_irq_req && !tx_irq_req |-> irq_vector == 16'h0000)
		else $error("vector without request");
	chk_irq_gated: assert property (!(rx_irq_req && !ie_r[0]) && !(tx_irq_req && !ie_r[1]))
		else $error("request while masked");
	chk_tx_pin_mux: assert property (en_r[1] ? tx_pin.oe : tx_pin == gpio_tx)
		else $error("transmit pin ownership wrong");
	chk_rx_pin_mux: assert property (en_r[0] ? !rx_pin.oe : rx_pin == gpio_rx)
		else $error("receive pin ownership wrong");
	chk_div_readback: assert property (reg_rd && reg_addr == 8'hE6 |=> reg_rdata == $past(div_r))
		else $error("divider readback wrong");
	chk_txbuf_readback: assert property (reg_rd && reg_addr == 8'hE7 |=> reg_rdata == $past(txd_r))
		else $error("transmit buffer readback wrong");
	chk_unmapped_zero: assert property (reg_rd && (reg_addr < 8'hE3 || reg_addr > 8'hE8) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
endmodule : uart_transceiver_props

bind uart_transceiver_baud_gen uart_transceiver_props u_uart_transceiver_props (
	.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
	.gpio_rx(gpio_rx), .gpio_tx(gpio_tx), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req),
	.irq_vector(irq_vector));
